// ### hw/irq_unit_pkg.sv
// constants for the interrupt unit: register map, field positions, reset values, timing counts
// assumes a 32-bit APB register bus with byte addresses; each register is one aligned word
package irq_unit_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_EDGE_SELECT = 8'h00;
  localparam logic [7:0] OFS_EDGE_FLAGS = 8'h04;
  localparam logic [7:0] OFS_EDGE_ENABLES = 8'h08;
  localparam logic [7:0] OFS_PORT_DIRECTION = 8'h0C;
  localparam logic [7:0] OFS_VECTOR_LO = 8'h10;
  localparam logic [7:0] OFS_VECTOR_HI = 8'h14;
  localparam logic [7:0] OFS_SAVED_PC_LO = 8'h18;
  localparam logic [7:0] OFS_SAVED_PC_HI = 8'h1C;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_PERIPH_ENABLES = 8'h24;
  localparam logic [7:0] OFS_ISR_SPEED = 8'h28;
  localparam logic [7:0] OFS_CUR_SPEED = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // control register fields
  localparam int CTRL_GIE_BIT = 0;
  // status register fields
  localparam int STAT_DEPTH_LSB = 0;
  localparam int STAT_OVERFLOW_BIT = 2;
  localparam int STAT_UNDERFLOW_BIT = 3;
  localparam int STAT_IRQ_BIT = 4;
  localparam int STAT_PERIPH_LSB = 8;

  // return instruction literal bits
  localparam int RETI_TIMER_BIT = 0;
  localparam int RETI_VECTOR_BIT = 1;
  localparam int RETI_SPEED_BIT = 2;

  // reset values
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_VECTOR_LO = 8'h00;
  localparam logic [7:0] RST_VECTOR_HI = 8'h00;
  localparam logic [7:0] RST_SPEED = 8'h00;

  // timing counts in system clock cycles, and the shadow stack depth in levels
  localparam int IRQ_HOLD_CYCLES = 2;
  localparam int FLASH_PUSH_DELAY = 4;
  localparam int SHADOW_DEPTH = 2;

endpackage

// ### hw/pin_edge_sense.sv
// one external port pin: two-flop synchroniser and selectable edge detector
// assumes pin_async is asynchronous to mclk; edge_hit is a one-cycle pulse
`timescale 1ns/100ps
module pin_edge_sense (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin_async,
  input wire logic falling_sel,
  input wire logic sense_en,
  output logic edge_hit
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic [1:0] fill;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_async;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // counts the pipeline refill after reset; prev is only a real pin sample
  // once it is full, so a pin held high through reset gives no false edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      fill <= 2'h0;
    end else if (fill != 2'h3) begin
      fill <= fill + 2'h1;
    end
  end

  // edge of the chosen polarity, only on pins set up as interrupt inputs
  always_comb begin
    if (falling_sel) begin
      edge_hit = sense_en & (fill == 2'h3) & prev & ~sync_b;
    end else begin
      edge_hit = sense_en & (fill == 2'h3) & ~prev & sync_b;
    end
  end
endmodule // pin_edge_sense

// ### hw/cpu_interrupt_unit.sv
// interrupt unit for a single-vector core: port edge flags, source gating, vector,
// saved pc, two-deep shadow stack and interrupt speed switching, with an APB slave.
// assumes the core pulses int_taken, swi_exec and reti_exec for one mclk cycle each.
//
// Behaviour
// - each port pin senses rising or falling edge
// - selected edge sets the pin's flag
// - port request ORs flag AND enable per pin
// - source needs own enable and global enable
// - software interrupt instruction raises interrupt, no enable
// - single rewritable vector in vector registers
// - entry saves current pc in saved-pc registers
// - return reloads pc from saved-pc registers
// - return option writes its address plus one
// - request held two cycles after flag clear
// - entry pushes core registers, two-deep stack
// - shadow stack separate from subroutine stack
// - flash data pushed four cycles after entry
// - return pops stack, restores shadowed registers; speed is restored only with return literal bit 2 set
// - entry clears global enable
// - return sets global enable
// - global enable set inside routine allows nesting
// - mainline set/clear of global enable works
// - return literal bit 1 enables vector update
// - entry shadows speed, loads interrupt speed
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module cpu_interrupt_unit #(
  parameter int PORT_PINS = 8,
  parameter int PERIPH_SRCS = 8,
  parameter int REGS_W = 32,
  parameter int SPEED_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external port pins and peripheral request levels
  input wire logic [PORT_PINS-1:0] port_pins,
  input wire logic [PERIPH_SRCS-1:0] periph_req,
  // core side
  input wire logic [15:0] core_pc,
  input wire logic [REGS_W-1:0] core_regs,
  input wire logic [7:0] flash_data_hi,
  input wire logic [7:0] flash_data_lo,
  input wire logic int_taken,
  input wire logic swi_exec,
  input wire logic reti_exec,
  input wire logic [2:0] reti_opts,
  input wire logic [15:0] reti_pc,
  output logic irq_req,
  output logic [15:0] vector_pc,
  output logic restore_valid,
  output logic [15:0] restore_pc,
  output logic [REGS_W-1:0] restore_regs,
  output logic [7:0] restore_flash_hi,
  output logic [7:0] restore_flash_lo,
  output logic timer_add_w,
  output logic [SPEED_W-1:0] current_speed_setting
);
  localparam int DEPTH = irq_unit_pkg::SHADOW_DEPTH;

  logic [PORT_PINS-1:0] edge_select;
  logic [PORT_PINS-1:0] edge_flags;
  logic [PORT_PINS-1:0] edge_enables;
  logic [PORT_PINS-1:0] port_direction;
  logic [PORT_PINS-1:0] edge_hit;
  logic [PERIPH_SRCS-1:0] periph_enables;
  logic [7:0] vector_lo;
  logic [7:0] vector_hi;
  logic gie;
  logic [SPEED_W-1:0] isr_speed_setting;
  logic overflow;
  logic underflow;
  logic [1:0] depth;
  logic [1:0] hold_cnt;
  logic [2:0] flash_cnt;
  logic flash_slot;
  logic src_req;
  logic src_held;
  logic port_req;
  logic swi_pend;
  logic ack;
  logic wr;
  logic mapped;
  logic [31:0] next_rdata;
  logic push_slot;
  logic pop_slot;

  // shadow stack storage, indexed by level
  logic [15:0] stk_pc [DEPTH];
  logic [REGS_W-1:0] stk_regs [DEPTH];
  logic [7:0] stk_fhi [DEPTH];
  logic [7:0] stk_flo [DEPTH];
  logic [SPEED_W-1:0] stk_speed [DEPTH];

  // one edge detector per port pin; pins flagged as inputs by a one in port_direction
  for (genvar i = 0; i < PORT_PINS; i++) begin : g_pin
    pin_edge_sense u_sense (
      .mclk(mclk),
      .rst(rst),
      .pin_async(port_pins[i]),
      .falling_sel(edge_select[i]),
      .sense_en(port_direction[i]),
      .edge_hit(edge_hit[i])
    );
  end

  // APB decode; no wait state, read data comes from a flop loaded in the setup cycle
  assign wr = psel & penable & ack & pwrite & (paddr[31:8] == 24'h000000); // unmapped: no effect
  assign pready = ack;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h00000000;
    unique case (paddr[7:0])
      irq_unit_pkg::OFS_EDGE_SELECT: next_rdata[PORT_PINS-1:0] = edge_select;
      irq_unit_pkg::OFS_EDGE_FLAGS: next_rdata[PORT_PINS-1:0] = edge_flags;
      irq_unit_pkg::OFS_EDGE_ENABLES: next_rdata[PORT_PINS-1:0] = edge_enables;
      irq_unit_pkg::OFS_PORT_DIRECTION: next_rdata[PORT_PINS-1:0] = port_direction;
      irq_unit_pkg::OFS_VECTOR_LO: next_rdata[7:0] = vector_lo;
      irq_unit_pkg::OFS_VECTOR_HI: next_rdata[7:0] = vector_hi;
      irq_unit_pkg::OFS_SAVED_PC_LO: next_rdata[7:0] = stk_pc[pop_slot][7:0];
      irq_unit_pkg::OFS_SAVED_PC_HI: next_rdata[7:0] = stk_pc[pop_slot][15:8];
      irq_unit_pkg::OFS_CONTROL: next_rdata[irq_unit_pkg::CTRL_GIE_BIT] = gie;
      irq_unit_pkg::OFS_PERIPH_ENABLES: next_rdata[PERIPH_SRCS-1:0] = periph_enables;
      irq_unit_pkg::OFS_ISR_SPEED: next_rdata[SPEED_W-1:0] = isr_speed_setting;
      irq_unit_pkg::OFS_CUR_SPEED: next_rdata[SPEED_W-1:0] = current_speed_setting;
      irq_unit_pkg::OFS_STATUS: begin
        next_rdata[irq_unit_pkg::STAT_DEPTH_LSB +: 2] = depth;
        next_rdata[irq_unit_pkg::STAT_OVERFLOW_BIT] = overflow;
        next_rdata[irq_unit_pkg::STAT_UNDERFLOW_BIT] = underflow;
        next_rdata[irq_unit_pkg::STAT_IRQ_BIT] = irq_req;
        next_rdata[irq_unit_pkg::STAT_PERIPH_LSB +: PERIPH_SRCS] = periph_req;
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[31:8] != 24'h000000) begin
      mapped = 1'b0;
      next_rdata = 32'h00000000;
    end
  end

  // answer flop: set by the setup cycle, dropped once the access completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      ack <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= ~mapped;
    end else if (psel & penable & ack) begin
      ack <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // plain software-owned configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      edge_select <= '0;
      edge_enables <= '0;
      port_direction <= irq_unit_pkg::RST_PORT_DIRECTION[PORT_PINS-1:0];
      periph_enables <= '0;
      isr_speed_setting <= irq_unit_pkg::RST_SPEED[SPEED_W-1:0];
    end else if (wr) begin
      unique case (paddr[7:0])
        irq_unit_pkg::OFS_EDGE_SELECT: edge_select <= pwdata[PORT_PINS-1:0];
        irq_unit_pkg::OFS_EDGE_ENABLES: edge_enables <= pwdata[PORT_PINS-1:0];
        irq_unit_pkg::OFS_PORT_DIRECTION: port_direction <= pwdata[PORT_PINS-1:0];
        irq_unit_pkg::OFS_PERIPH_ENABLES: periph_enables <= pwdata[PERIPH_SRCS-1:0];
        irq_unit_pkg::OFS_ISR_SPEED: isr_speed_setting <= pwdata[SPEED_W-1:0];
        default: ;
      endcase
    end
  end

  // edge flags: write one to clear, a new edge in the same cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      edge_flags <= '0;
    end else if (wr && paddr[7:0] == irq_unit_pkg::OFS_EDGE_FLAGS) begin
      edge_flags <= (edge_flags & ~pwdata[PORT_PINS-1:0]) | edge_hit;
    end else begin
      edge_flags <= edge_flags | edge_hit;
    end
  end

  // vector: software may rewrite it any time; a return with the option set takes priority
  always_ff @(posedge mclk) begin
    if (rst) begin
      vector_lo <= irq_unit_pkg::RST_VECTOR_LO;
      vector_hi <= irq_unit_pkg::RST_VECTOR_HI;
    end else if (reti_exec & reti_opts[irq_unit_pkg::RETI_VECTOR_BIT]) begin
      {vector_hi, vector_lo} <= reti_pc + 16'h0001;
    end else if (wr && paddr[7:0] == irq_unit_pkg::OFS_VECTOR_LO) begin
      vector_lo <= pwdata[7:0];
    end else if (wr && paddr[7:0] == irq_unit_pkg::OFS_VECTOR_HI) begin
      vector_hi <= pwdata[7:0];
    end
  end
  assign vector_pc = {vector_hi, vector_lo};

  // global enable: entry clears, return sets, software writes otherwise
  always_ff @(posedge mclk) begin
    if (rst) begin
      gie <= 1'b0;
    end else if (int_taken) begin
      gie <= 1'b0;
    end else if (reti_exec) begin
      gie <= 1'b1;
    end else if (wr && paddr[7:0] == irq_unit_pkg::OFS_CONTROL) begin
      gie <= pwdata[irq_unit_pkg::CTRL_GIE_BIT];
    end
  end

  // software interrupt stays pending until the core takes it
  always_ff @(posedge mclk) begin
    if (rst) begin
      swi_pend <= 1'b0;
    end else if (swi_exec) begin
      swi_pend <= 1'b1;
    end else if (int_taken) begin
      swi_pend <= 1'b0;
    end
  end

  // source gating; the hold counter keeps a cleared source visible for two cycles,
  // so a return issued too soon after the clear is taken again
  assign port_req = |(edge_flags & edge_enables);
  assign src_req = port_req | (|(periph_req & periph_enables));
  assign src_held = src_req | (hold_cnt != 2'd0);
  assign irq_req = (gie & src_held) | swi_pend;

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cnt <= 2'd0;
    end else if (src_req) begin
      hold_cnt <= 2'(irq_unit_pkg::IRQ_HOLD_CYCLES);
    end else if (hold_cnt != 2'd0) begin
      hold_cnt <= hold_cnt - 2'd1;
    end
  end

  // stack pointer: its own storage, no link to the subroutine call stack
  assign push_slot = (depth == 2'd0) ? 1'b0 : 1'b1;
  assign pop_slot = (depth == 2'd2) ? 1'b1 : 1'b0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      depth <= 2'd0;
      overflow <= 1'b0;
      underflow <= 1'b0;
    end else begin
      if (int_taken) begin
        if (depth == 2'(DEPTH)) begin
          overflow <= 1'b1; // top level is overwritten
        end else begin
          depth <= depth + 2'd1;
        end
      end else if (reti_exec) begin
        if (depth == 2'd0) begin
          underflow <= 1'b1;
        end else begin
          depth <= depth - 2'd1;
        end
      end
      if (wr && paddr[7:0] == irq_unit_pkg::OFS_STATUS) begin
        // sticky errors clear on a one, unless raised again in this cycle
        if (pwdata[irq_unit_pkg::STAT_OVERFLOW_BIT] && !(int_taken && depth == 2'(DEPTH))) begin
          overflow <= 1'b0;
        end
        if (pwdata[irq_unit_pkg::STAT_UNDERFLOW_BIT] && !(reti_exec && depth == 2'd0)) begin
          underflow <= 1'b0;
        end
      end
    end
  end

  // entry push of pc, core registers and speed; flash data waits for a pending fetch
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < DEPTH; k++) begin
        stk_pc[k] <= 16'h0000;
        stk_regs[k] <= '0;
        stk_speed[k] <= '0;
      end
    end else if (int_taken) begin
      stk_pc[push_slot] <= core_pc;
      stk_regs[push_slot] <= core_regs;
      stk_speed[push_slot] <= current_speed_setting;
    end
  end

  // delayed flash data push, counted from the entry edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_cnt <= 3'd0;
      flash_slot <= 1'b0;
      for (int k = 0; k < DEPTH; k++) begin
        stk_fhi[k] <= 8'h00;
        stk_flo[k] <= 8'h00;
      end
    end else if (int_taken) begin
      flash_cnt <= 3'(irq_unit_pkg::FLASH_PUSH_DELAY);
      flash_slot <= push_slot;
    end else if (flash_cnt != 3'd0) begin
      flash_cnt <= flash_cnt - 3'd1;
      if (flash_cnt == 3'd1) begin
        stk_fhi[flash_slot] <= flash_data_hi;
        stk_flo[flash_slot] <= flash_data_lo;
      end
    end
  end

  // speed: entry switches to the interrupt speed, return may restore the saved one
  always_ff @(posedge mclk) begin
    if (rst) begin
      current_speed_setting <= irq_unit_pkg::RST_SPEED[SPEED_W-1:0];
    end else if (int_taken) begin
      current_speed_setting <= isr_speed_setting;
    end else if (reti_exec && reti_opts[irq_unit_pkg::RETI_SPEED_BIT] && depth != 2'd0) begin
      current_speed_setting <= stk_speed[pop_slot];
    end
  end

  // return: one-cycle restore pulse with the popped level on registered outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      restore_valid <= 1'b0;
      restore_pc <= 16'h0000;
      restore_regs <= '0;
      restore_flash_hi <= 8'h00;
      restore_flash_lo <= 8'h00;
      timer_add_w <= 1'b0;
    end else begin
      restore_valid <= reti_exec & (depth != 2'd0);
      timer_add_w <= reti_exec & reti_opts[irq_unit_pkg::RETI_TIMER_BIT];
      if (reti_exec && depth != 2'd0) begin
        restore_pc <= stk_pc[pop_slot];
        restore_regs <= stk_regs[pop_slot];
        restore_flash_hi <= stk_fhi[pop_slot];
        restore_flash_lo <= stk_flo[pop_slot];
      end
    end
  end
endmodule // cpu_interrupt_unit

// ### verif/core_model.sv
// behavioural core beside the interrupt unit: takes requests, jumps, resumes
// assumes the unit registers int_taken at the next mclk edge
`timescale 1ns/100ps
module core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic take_en,
  input wire logic restore_valid,
  input wire logic [15:0] vector_pc,
  input wire logic [15:0] restore_pc,
  output logic int_taken,
  output logic [15:0] core_pc,
  output logic [31:0] core_regs,
  output logic [7:0] flash_data_hi,
  output logic [7:0] flash_data_lo
);
  // one pulse per request; pc moves every cycle so a late sample shows
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_taken <= 1'h0;
      core_pc <= 16'h0100;
    end else begin
      int_taken <= irq_req & take_en & !int_taken;
      if (int_taken) core_pc <= vector_pc;
      else if (restore_valid) core_pc <= restore_pc;
      else core_pc <= core_pc + 16'h0001;
    end
  end
  // flash data only follows the pc, never accessed on routine entry
  assign flash_data_hi = core_pc[7:0] ^ 8'h5C;
  assign flash_data_lo = ~core_pc[7:0];
  assign core_regs = {core_pc, ~core_pc};
endmodule // core_model

// ### verif/irq_unit_assertions.sv
// checker for the interrupt unit: core-side relations at the top ports
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/100ps
module irq_unit_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic int_taken,
  input wire logic swi_exec,
  input wire logic reti_exec,
  input wire logic [2:0] reti_opts,
  input wire logic [15:0] reti_pc,
  input wire logic [15:0] core_pc,
  input wire logic irq_req,
  input wire logic [15:0] vector_pc,
  input wire logic restore_valid,
  input wire logic [15:0] restore_pc,
  input wire logic timer_add_w,
  input wire logic [7:0] current_speed_setting
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // two-deep pc stack; overflow overwrites the top like the unit does
  logic [15:0] pc0, pc1;
  logic [1:0] dep;
  always_ff @(posedge mclk) begin
    if (rst) begin
      dep <= 2'h0;
    end else if (int_taken) begin
      if (dep == 2'h0) pc0 <= core_pc;
      else pc1 <= core_pc;
      if (dep != 2'h2) dep <= dep + 2'h1;
    end else if (reti_exec && dep != 2'h0) begin
      dep <= dep - 2'h1;
    end
  end
  vec_update_a: assert property (reti_exec && reti_opts[1] && !int_taken
    |=> vector_pc == $past(reti_pc) + 16'h0001) else $error("vector not reloaded");
  vec_hold_a: assert property (!(psel && penable && pwrite) && !reti_exec
    |=> $stable(vector_pc)) else $error("vector moved by itself");
  entry_mask_a: assert property (int_taken && !swi_exec |=> !irq_req)
    else $error("request stays after entry");
  swi_raise_a: assert property (swi_exec && !int_taken |=> irq_req)
    else $error("software interrupt not raised");
  timer_pulse_a: assert property (reti_exec && reti_opts[0] && !int_taken
    |=> timer_add_w) else $error("timer add missing");
  restore_cause_a: assert property (restore_valid |-> $past(reti_exec))
    else $error("restore without return");
  pop_valid_a: assert property (reti_exec && !int_taken && dep != 2'h0
    |=> restore_valid) else $error("return did not pop");
  restore_pc_a: assert property (restore_valid
    |-> restore_pc == ($past(dep) == 2'h2 ? $past(pc1) : $past(pc0)))
    else $error("restored pc wrong");
  speed_cause_a: assert property ($changed(current_speed_setting)
    |-> $past(int_taken) || $past(reti_exec)) else $error("speed changed alone");
  entry_c: cover property (int_taken);
  nested_c: cover property (restore_valid && $past(dep) == 2'h2);
  timer_c: cover property (timer_add_w);
endmodule // irq_unit_chk

bind cpu_interrupt_unit irq_unit_chk chk_i (.mclk, .rst, .psel, .penable, .pwrite,
  .int_taken, .swi_exec, .reti_exec, .reti_opts, .reti_pc, .core_pc, .irq_req,
  .vector_pc, .restore_valid, .restore_pc, .timer_add_w, .current_speed_setting);

// ### verif/tb_cpu_interrupt_unit.sv
// self-checking bench for the interrupt unit with a behavioural core
// assumes the default parameters and no wait state on any APB transfer
`timescale 1ns/100ps
module tb_cpu_interrupt_unit;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, take_en;
  logic int_taken, swi_exec, reti_exec, irq_req, restore_valid, timer_add_w;
  logic [31:0] paddr, pwdata, prdata, rd, core_regs, restore_regs, regs1;
  logic [7:0] port_pins, periph_req, flash_data_hi, flash_data_lo, fh, fl;
  logic [7:0] restore_flash_hi, restore_flash_lo, current_speed_setting;
  logic [15:0] core_pc, reti_pc, vector_pc, restore_pc, pc1, pc2;
  logic [2:0] reti_opts;
  int mismatches = 0, compares = 0, cyc = 0, n;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic er;} row_t;
  // write rows carry data, read rows carry the expected word
  row_t rows [15] = '{'{1'h0, 8'h0C, 32'hFF, 1'h0}, '{1'h0, 8'h10, 32'h0, 1'h0},
    '{1'h0, 8'h14, 32'h0, 1'h0}, '{1'h0, 8'h2C, 32'h0, 1'h0}, '{1'h0, 8'h20, 32'h0, 1'h0},
    '{1'h0, 8'h30, 32'h0, 1'h0}, '{1'h1, 8'h10, 32'h34, 1'h0}, '{1'h1, 8'h14, 32'h12, 1'h0},
    '{1'h0, 8'h10, 32'h34, 1'h0}, '{1'h0, 8'h14, 32'h12, 1'h0}, '{1'h1, 8'h2C, 32'h77, 1'h0},
    '{1'h0, 8'h2C, 32'h0, 1'h0}, '{1'h1, 8'h28, 32'h5A, 1'h0}, '{1'h0, 8'h28, 32'h5A, 1'h0},
    '{1'h0, 8'h40, 32'h0, 1'h1}};

  cpu_interrupt_unit uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_pins, .periph_req, .core_pc, .core_regs,
    .flash_data_hi, .flash_data_lo, .int_taken, .swi_exec, .reti_exec, .reti_opts,
    .reti_pc, .irq_req, .vector_pc, .restore_valid, .restore_pc, .restore_regs,
    .restore_flash_hi, .restore_flash_lo, .timer_add_w, .current_speed_setting);
  core_model cm (.mclk, .rst, .irq_req, .take_en, .restore_valid, .vector_pc,
    .restore_pc, .int_taken, .core_pc, .core_regs, .flash_data_hi, .flash_data_lo);

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      finish_test();
    end
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one APB transfer; waits for pready, then checks it came on the first access edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1);
    chk("access edges", 1, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task irq(input logic e);
    #1;
    chk("irq_req", e, irq_req);
  endtask
  // wait for the core to take; record pc, regs and the flash word at entry+4
  task take(output logic [15:0] p);
    n = 0;
    while (int_taken !== 1'h1 && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("int_taken", 1, int_taken);
    p = core_pc;
    regs1 = core_regs;
    @(posedge mclk);
    irq(1'h0);
    repeat (3) @(posedge mclk);
    #1;
    fh = flash_data_hi;
    fl = flash_data_lo;
  endtask
  task reti(input logic [2:0] o, input logic [15:0] p);
    @(posedge mclk);
    reti_exec <= 1'h1;
    reti_opts <= o;
    reti_pc <= p;
    @(posedge mclk);
    reti_exec <= 1'h0;
    #1;
    chk("restore_valid", 1, restore_valid);
    chk("timer_add_w", o[0], timer_add_w);
  endtask
  task pins(input logic [7:0] v);
    @(posedge mclk);
    port_pins <= v;
    repeat (6) @(posedge mclk);
  endtask

  initial begin
    {rst, take_en} = 2'h3;
    {psel, penable, pwrite, swi_exec, reti_exec} = 5'h0;
    {paddr, pwdata, periph_req, reti_opts, reti_pc} = 0;
    port_pins = 8'h0F;
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    take_en <= 1'h0;
    for (int i = 0; i < 15; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("rd", rows[i].d, rd);
      chk("pslverr", rows[i].er, er);
    end
    chk("vector_pc", 16'h1234, vector_pc);
    // pins 0-3 sense falling edges, 4-7 rising
    apb(1'h1, 8'h00, 32'h0F);
    apb(1'h1, 8'h04, 32'hFF);
    pins(8'hF0);
    rdc("flags", 8'h04, 32'hFF);
    apb(1'h1, 8'h04, 32'hFF);
    pins(8'h0F);
    rdc("flags", 8'h04, 32'h0);
    pins(8'hF0);
    apb(1'h1, 8'h20, 32'h1);
    irq(1'h0);
    apb(1'h1, 8'h08, 32'h80);
    irq(1'h1);
    apb(1'h1, 8'h20, 32'h0);
    irq(1'h0);
    apb(1'h1, 8'h20, 32'h1);
    irq(1'h1);
    // request lasts exactly two cycles past the clearing write
    apb(1'h1, 8'h04, 32'h80);
    irq(1'h1);
    @(posedge mclk);
    irq(1'h1);
    @(posedge mclk);
    irq(1'h0);
    // entry from pin 0, return with every option bit set
    apb(1'h1, 8'h08, 32'h01);
    take_en <= 1'h1;
    take(pc1);
    rdc("saved_lo", 8'h18, {24'h0, pc1[7:0]});
    rdc("saved_hi", 8'h1C, {24'h0, pc1[15:8]});
    rdc("speed", 8'h2C, 32'h5A);
    rdc("gie", 8'h20, 32'h0);
    rdc("status", 8'h30, 32'h1);
    apb(1'h1, 8'h04, 32'h01);
    repeat (2) @(posedge mclk);
    reti(3'h7, 16'h2000);
    chk("restore_pc", pc1, restore_pc);
    chk("restore_regs", regs1, restore_regs);
    chk("flash_hi", fh, restore_flash_hi);
    chk("flash_lo", fl, restore_flash_lo);
    chk("vector_pc", 16'h2001, vector_pc);
    rdc("speed", 8'h2C, 32'h0);
    rdc("gie", 8'h20, 32'h1);
    // software interrupt with gie off, then a nested peripheral request
    apb(1'h1, 8'h20, 32'h0);
    @(posedge mclk);
    swi_exec <= 1'h1;
    @(posedge mclk);
    swi_exec <= 1'h0;
    take(pc1);
    apb(1'h1, 8'h24, 32'h04);
    periph_req <= 8'h04;
    irq(1'h0);
    apb(1'h1, 8'h20, 32'h1);
    take(pc2);
    rdc("status", 8'h30, 32'h402);
    apb(1'h1, 8'h24, 32'h0);
    repeat (2) @(posedge mclk);
    reti(3'h0, 16'h3000);
    chk("restore_pc", pc2, restore_pc);
    reti(3'h0, 16'h3000);
    chk("restore_pc", pc1, restore_pc);
    chk("vector_pc", 16'h2001, vector_pc);
    rdc("speed", 8'h2C, 32'h5A);
    repeat (4) @(posedge mclk);
    irq(1'h0);
    rdc("gie", 8'h20, 32'h1);
    // a return with nothing stacked only raises the sticky underflow
    @(posedge mclk);
    reti_exec <= 1'h1;
    @(posedge mclk);
    reti_exec <= 1'h0;
    #1;
    chk("restore_valid", 0, restore_valid);
    rdc("status", 8'h30, 32'h408);
    apb(1'h1, 8'h30, 32'h8);
    rdc("status", 8'h30, 32'h400);
    // reset again in mid-run, pins 4-7 held high through it
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    irq(1'h0);
    chk("vector_pc", 16'h0, vector_pc);
    rdc("direction", 8'h0C, 32'hFF);
    rdc("flags", 8'h04, 32'h0);
    finish_test();
  end
endmodule // tb_cpu_interrupt_unit
